// >>> bench/tb_top.sv
// Self-checking bench for the timer interrupt enable and status block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tif_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, timer_irq, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, slave_mode;
  logic [31:0] hwdata, hrdata, q, exp;
  logic break_input, trigger_input, commutation_event, update_event;
  logic chan5_event;
  logic [4:1] chan_event, chan_is_input;
  int mismatches = 0;
  int num_checks = 0;
  tif_top #(.NCHAN(4)) tif_top_inst (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .break_input, .trigger_input, .slave_mode,
    .commutation_event, .update_event, .chan_event, .chan_is_input,
    .chan5_event, .timer_irq);
  initial begin
    hclk = 0;
    forever #2 hclk = ~hclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One single word transfer; the address phase is held until hready is high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= TIF_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= TIF_HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(n, e, q);
  endtask
  task automatic pulse(input logic [4:1] c, input logic u, input logic cm);
    chan_event <= c;
    update_event <= u;
    commutation_event <= cm;
    chan5_event <= u;
    @(posedge hclk);
    chan_event <= 4'h0;
    update_event <= 1'b0;
    commutation_event <= 1'b0;
    chan5_event <= 1'b0;
    @(posedge hclk);
  endtask
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
  initial begin
    {hsel, hwrite, break_input, trigger_input, commutation_event} = '0;
    {update_event, chan5_event, chan_event, chan_is_input} = '0;
    {haddr, htrans, hsize, slave_mode, hwdata} = '0;
    hresetn = 1'b0;
    tick(3);
    hresetn <= 1'b1;
    rdchk("ien_reset", TIF_IEN_OFS, 32'h0000_0000);
    rdchk("sts_reset", TIF_STS_OFS, 32'h0000_0000);
    chk("hresp_okay", 32'h0, {31'h0, hresp});
    xfer(1'b1, TIF_IEN_OFS, 32'h0000_00FF);
    rdchk("ien_rw", TIF_IEN_OFS, 32'h0000_00FF);
    xfer(1'b1, TIF_IEN_OFS, 32'h0000_0000);
    pulse(4'hF, 1'b1, 1'b1);
    exp = 32'h0001_003F;
    rdchk("sts_events", TIF_STS_OFS, exp);
    chk("irq_masked", 32'h0, {31'h0, timer_irq});
    // Each of enable bits 0 to 5 alone must raise the request, then a written zero drops it.
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, TIF_IEN_OFS, 32'h1 << i);
      tick(2);
      chk("irq_on", 32'h1, {31'h0, timer_irq});
      xfer(1'b1, TIF_STS_OFS, ~(32'h1 << i) & TIF_STS_MASK);
      exp = exp & ~(32'h1 << i);
      tick(2);
      chk("irq_off", 32'h0, {31'h0, timer_irq});
      rdchk("sts_clear", TIF_STS_OFS, exp);
    end
    chan_is_input <= 4'h1;
    pulse(4'h3, 1'b0, 1'b0);
    pulse(4'h3, 1'b0, 1'b0);
    rdchk("overcapture", TIF_STS_OFS, 32'h0001_0206);
    xfer(1'b1, TIF_STS_OFS, 32'h0000_0000);
    xfer(1'b1, TIF_IEN_OFS, 32'h0000_00C0);
    break_input <= 1'b1;
    tick(5);
    rdchk("break_flag", TIF_STS_OFS, 32'h0000_0080);
    chk("irq_break", 32'h1, {31'h0, timer_irq});
    break_input <= 1'b0;
    tick(4);
    xfer(1'b1, TIF_STS_OFS, 32'h0000_0000);
    rdchk("break_clr", TIF_STS_OFS, 32'h0000_0000);
    // Outside gated mode only the rising edge counts; in gated mode both do.
    for (int m = 0; m < 2; m++) begin
      slave_mode <= m ? TIF_SM_GATED : 3'h6;
      trigger_input <= 1'b1;
      tick(6);
      chk("irq_trig", 32'h1, {31'h0, timer_irq});
      rdchk("trig_rise", TIF_STS_OFS, 32'h0000_0040);
      xfer(1'b1, TIF_STS_OFS, 32'h0000_0000);
      trigger_input <= 1'b0;
      tick(6);
      rdchk("trig_fall", TIF_STS_OFS, m ? 32'h40 : 32'h0);
      xfer(1'b1, TIF_STS_OFS, 32'h0000_0000);
    end
    // A reset in mid-run must drop every flag, enable and the request.
    xfer(1'b1, TIF_IEN_OFS, 32'h0000_00FF);
    pulse(4'h0, 1'b1, 1'b0);
    chk("irq_pre_rst", 32'h1, {31'h0, timer_irq});
    hresetn <= 1'b0;
    tick(3);
    hresetn <= 1'b1;
    rdchk("ien_rst2", TIF_IEN_OFS, 32'h0000_0000);
    rdchk("sts_rst2", TIF_STS_OFS, 32'h0000_0000);
    chk("irq_rst2", 32'h0, {31'h0, timer_irq});
    rdchk("unmapped", 8'h04, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> hdl/tif_pkg.sv
// Package with register map, field positions and the gated slave-mode code.
package tif_pkg;
  localparam logic [7:0] TIF_IEN_OFS = 8'h0C;
  localparam logic [7:0] TIF_STS_OFS = 8'h10;
  localparam logic [15:0] TIF_IEN_RST = 16'h0000;
  localparam logic [31:0] TIF_STS_RST = 32'h0000_0000;
  localparam int TIF_UPD = 0;
  localparam int TIF_CH1 = 1;
  localparam int TIF_COM = 5;
  localparam int TIF_TRG = 6;
  localparam int TIF_BRK = 7;
  localparam int TIF_OVC1 = 9;
  localparam int TIF_CH5 = 16;
  localparam logic [15:0] TIF_IEN_MASK = 16'h00FF;
  localparam logic [31:0] TIF_STS_MASK = 32'h0001_1EFF;
  localparam logic [2:0] TIF_SM_GATED = 3'h5;
  localparam logic [1:0] TIF_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] TIF_HSIZE_WORD = 3'h2;
endpackage

// >>> hdl/tif_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/100ps
`default_nettype none
module tif_sync #(
  parameter int WIDTH = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/tif_top.sv
// Timer interrupt enable and status flag block with an AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none
module tif_top
  import tif_pkg::*;
#(
  parameter int NCHAN = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic break_input,
  input wire logic trigger_input,
  input wire logic [2:0] slave_mode,
  input wire logic commutation_event,
  input wire logic update_event,
  input wire logic [NCHAN:1] chan_event,
  input wire logic [NCHAN:1] chan_is_input,
  input wire logic chan5_event,
  output logic timer_irq
);
  if (NCHAN != 4) begin : g_nchan_check
    $error("tif_top supports exactly four capture channels");
  end

  logic brk_s;
  logic trg_s;
  logic trg_d_r;
  logic trg_rise;
  logic trg_fall;
  logic trg_hit;
  logic [15:0] ien_r;
  logic [15:0] ien_nxt;
  logic [NCHAN:1] ovc_set;
  logic [31:0] sts_r;
  logic [31:0] sts_nxt;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic ph_wr_r;
  logic ph_rd_r;
  logic [7:0] ph_addr_r;
  logic take;
  logic wr_ien;
  logic wr_sts;

  // Break and trigger come from pins, so they are synchronised first.
  tif_sync #(.WIDTH(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({break_input, trigger_input}),
    .sync_out({brk_s, trg_s})
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trg_d_r <= 1'b0;
    end else begin
      trg_d_r <= trg_s;
    end
  end

  assign trg_rise = trg_s && !trg_d_r;
  assign trg_fall = !trg_s && trg_d_r;
  // Gated mode counts both edges; others count the rising edge only.
  assign trg_hit = (slave_mode == TIF_SM_GATED) ? (trg_rise || trg_fall)
                                                : trg_rise;

  // Bus address phase capture; the slave never inserts wait states.
  assign take = hsel && hready && (htrans == TIF_HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else begin
      ph_wr_r <= take && hwrite && (hsize == TIF_HSIZE_WORD);
      ph_rd_r <= take && !hwrite;
      ph_addr_r <= take ? haddr : ph_addr_r;
    end
  end

  assign wr_ien = ph_wr_r && (ph_addr_r == TIF_IEN_OFS);
  assign wr_sts = ph_wr_r && (ph_addr_r == TIF_STS_OFS);

  // Reserved enable bits are held at their reset value whatever is written.
  // Reads use the next value, so a read right behind a write sees the word.
  assign ien_nxt = wr_ien ? (hwdata[15:0] & TIF_IEN_MASK) : ien_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_r <= TIF_IEN_RST;
    end else begin
      ien_r <= ien_nxt;
    end
  end

  // A capture while the channel flag is still up is an overcapture.
  for (genvar c = 1; c <= NCHAN; c++) begin : g_chan
    assign ovc_set[c] = chan_event[c] && chan_is_input[c]
                        && sts_r[TIF_CH1 + c - 1];
  end

  // Hardware set sources, one bit per flag.
  always_comb begin
    set_vec = '0;
    set_vec[TIF_UPD] = update_event;
    set_vec[TIF_CH1 +: NCHAN] = chan_event;
    set_vec[TIF_OVC1 +: NCHAN] = ovc_set;
    set_vec[TIF_COM] = commutation_event;
    set_vec[TIF_TRG] = trg_hit;
    set_vec[TIF_BRK] = brk_s;
    set_vec[TIF_CH5] = chan5_event;
  end

  // A written zero clears; a written one leaves the flag alone.
  assign clr_vec = wr_sts ? (~hwdata & TIF_STS_MASK) : '0;
  // Set wins over clear so no event is lost in the clearing cycle.
  assign sts_nxt = ((sts_r & ~clr_vec) | set_vec) & TIF_STS_MASK;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_r <= TIF_STS_RST;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr)
        TIF_IEN_OFS: hrdata <= {16'h0000, ien_nxt};
        TIF_STS_OFS: hrdata <= sts_nxt;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Overcapture and channel 5 flags carry no enable of their own.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(sts_nxt[TIF_BRK:TIF_UPD]
                     & ien_r[TIF_BRK:TIF_UPD]);
    end
  end

  property brk_sets_p;
    @(posedge hclk) disable iff (!hresetn)
      brk_s |=> sts_r[TIF_BRK];
  endproperty
  brk_flag_a: assert property (brk_sets_p)
    else $error("break flag not set while break active");

  property one_keeps_p;
    @(posedge hclk) disable iff (!hresetn)
      wr_sts && hwdata[TIF_UPD] && sts_r[TIF_UPD] |=> sts_r[TIF_UPD];
  endproperty
  write_one_a: assert property (one_keeps_p)
    else $error("writing one cleared a flag");

  property zero_clears_p;
    @(posedge hclk) disable iff (!hresetn)
      wr_sts && !hwdata[TIF_CH5] && !chan5_event |=> !sts_r[TIF_CH5];
  endproperty
  ch5_clear_a: assert property (zero_clears_p)
    else $error("channel 5 flag not cleared by zero");

  property ovc_needs_p;
    @(posedge hclk) disable iff (!hresetn)
      $rose(sts_r[TIF_OVC1]) |-> $past(sts_r[TIF_CH1])
        && $past(chan_is_input[1]) && $past(chan_event[1]);
  endproperty
  ovc_cause_a: assert property (ovc_needs_p)
    else $error("overcapture set without cause");

  sequence trg_fall_s;
    trg_d_r && !trg_s;
  endsequence
  property gated_fall_p;
    @(posedge hclk) disable iff (!hresetn)
      (slave_mode == TIF_SM_GATED) and trg_fall_s |=> sts_r[TIF_TRG];
  endproperty
  gated_edge_a: assert property (gated_fall_p)
    else $error("falling edge in gated mode missed");

  property nongated_fall_p;
    @(posedge hclk) disable iff (!hresetn)
      slave_mode != TIF_SM_GATED && !trg_rise && !sts_r[TIF_TRG]
        |=> !sts_r[TIF_TRG];
  endproperty
  trg_quiet_a: assert property (nongated_fall_p)
    else $error("trigger flag set without rising edge");

  property com_sets_p;
    @(posedge hclk) disable iff (!hresetn)
      commutation_event |=> sts_r[TIF_COM];
  endproperty
  com_flag_a: assert property (com_sets_p)
    else $error("commutation flag not set");

  property irq_p;
    @(posedge hclk) disable iff (!hresetn)
      timer_irq == |(sts_r[TIF_BRK:TIF_UPD] & $past(ien_r[TIF_BRK:TIF_UPD]));
  endproperty
  irq_gate_a: assert property (irq_p)
    else $error("interrupt request disagrees with flags");

  property ien_resv_p;
    @(posedge hclk) disable iff (!hresetn)
      ien_r[15:8] == 8'h00;
  endproperty
  ien_resv_a: assert property (ien_resv_p)
    else $error("reserved enable bits not zero");

  property trg_rise_p;
    @(posedge hclk) disable iff (!hresetn)
      (slave_mode != TIF_SM_GATED) && trg_rise |=> sts_r[TIF_TRG];
  endproperty
  trg_rise_a: assert property (trg_rise_p)
    else $error("trigger flag not set on rising edge");

  property gated_rise_p;
    @(posedge hclk) disable iff (!hresetn)
      (slave_mode == TIF_SM_GATED) && trg_rise |=> sts_r[TIF_TRG];
  endproperty
  gated_rise_a: assert property (gated_rise_p)
    else $error("rising edge in gated mode missed");

  property ovc_sets_p;
    @(posedge hclk) disable iff (!hresetn)
      chan_event[1] && chan_is_input[1] && sts_r[TIF_CH1]
        |=> sts_r[TIF_OVC1];
  endproperty
  ovc_set_a: assert property (ovc_sets_p)
    else $error("overcapture not flagged");

  property ovc_input_p;
    @(posedge hclk) disable iff (!hresetn)
      !chan_is_input[1] && !sts_r[TIF_OVC1] |=> !sts_r[TIF_OVC1];
  endproperty
  ovc_mode_a: assert property (ovc_input_p)
    else $error("overcapture set outside input capture");

  sequence upd_clear_s;
    wr_sts && !hwdata[TIF_UPD] && !update_event;
  endsequence
  property upd_clear_p;
    @(posedge hclk) disable iff (!hresetn)
      upd_clear_s |=> !sts_r[TIF_UPD];
  endproperty
  upd_clear_a: assert property (upd_clear_p)
    else $error("update flag not cleared by zero");

  property ien_write_p;
    @(posedge hclk) disable iff (!hresetn)
      wr_ien |=> ien_r[TIF_BRK:TIF_UPD] == $past(hwdata[TIF_BRK:TIF_UPD]);
  endproperty
  ien_write_a: assert property (ien_write_p)
    else $error("enable write did not land");

  property irq_off_p;
    @(posedge hclk) disable iff (!hresetn)
      ien_r[TIF_BRK:TIF_UPD] == 8'h00 |=> !timer_irq;
  endproperty
  irq_off_a: assert property (irq_off_p)
    else $error("interrupt request without enable");
endmodule
`default_nettype wire
